//--- hdl/chicr_regs.sv
// Interrupt mask, configuration and write-protect registers of the card host controller.
// Contract
// - Byte sent without written data sets underrun.
// - New transfer command or flow bit set clears underrun.
// - Status read clears underrun when flow bit set.
// - Enable, disable, mask follow status bit layout.
// - Enable write sets mask bits written one.
// - Disable write clears mask bits written one.
// - Mask register reads current enable state.
// - Configuration writes ignored while protection enabled.
// - Long block starts write at half FIFO.
// - Medium block starts write at quarter FIFO.
// - Short block starts write when fully loaded.
// - Start mode one starts after one word.
// - Flow bit zero keeps flags until command.
// - Flow bit one clears flags on status read.
// - High-speed bit selects rising card clock edge.
// - Sync bit zero issues command at block end.
// - Sync bit one issues command at transfer end.
// - Protect mode write needs the correct key.
// - Keyed write sets or clears write protection.
`timescale 1ns/1ps
`default_nettype none

module chicr_regs
  import chicr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // Register port.
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Status flags and events from the card protocol engine.
  input  wire logic [29:0] status_flags_i,
  input  wire logic        tx_underrun_evt_i,
  input  wire logic        rx_overrun_evt_i,
  input  wire logic        xfer_cmd_i,
  // Write FIFO fill state for the start decision.
  input  wire logic [15:0] block_len_i,
  input  wire logic [15:0] xfer_bytes_i,
  input  wire logic [15:0] fifo_level_i,
  // Pending command timing.
  input  wire logic        cmd_pending_i,
  input  wire logic        block_end_i,
  input  wire logic        xfer_end_i,
  // Outputs to the protocol engine and the system.
  output logic             irq_o,
  output logic             wr_start_ok_o,
  output logic             cmd_issue_o,
  output logic             high_speed_edge_o,
  output logic             wprot_enable_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and decoded strobes.
  chicr_state_t st_reg;
  chicr_state_t st_next;

  logic        wr_irq_set;
  logic        wr_irq_clr;
  logic        wr_cfg;
  logic        wr_cfg_ok;
  logic        wr_wprot;
  logic        wprot_key_ok;
  logic        rd_status;
  logic        rd_flow_clear;
  logic [31:0] flags_now;
  logic [31:0] wdata_valid;

  // Address decode; each strobe is qualified by its own bus strobe.
  assign wr_irq_set   = reg_wr_i && (reg_addr_i == ADDR_IRQ_SET);
  assign wr_irq_clr   = reg_wr_i && (reg_addr_i == ADDR_IRQ_CLR);
  assign wr_cfg       = reg_wr_i && (reg_addr_i == ADDR_HOST_CFG);
  assign wr_cfg_ok    = wr_cfg && !st_reg.wprot_enable;
  assign wr_wprot     = reg_wr_i && (reg_addr_i == ADDR_WPROT_MODE);
  assign wprot_key_ok = reg_wdata_i[WP_KEY_MSB:WP_KEY_LSB] == WP_KEY_VALUE;
  assign rd_status    = reg_rd_i && (reg_addr_i == ADDR_STATUS);
  assign rd_flow_clear = rd_status && st_reg.flow_err_reset_ctrl;
  assign wdata_valid  = reg_wdata_i & FLAG_VALID_MASK;

  // Status view: two flow flags held here, the rest from the engine.
  assign flags_now = {st_reg.tx_underrun_flag, st_reg.rx_overrun_flag, status_flags_i}
                     & FLAG_VALID_MASK;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole slice.
  always_comb begin
    st_next = st_reg;

    // Mask: clear is applied after set and would win, though the bus
    // never carries two writes in one cycle.
    if (wr_irq_set) begin
      st_next.mask = st_reg.mask | wdata_valid;
    end
    if (wr_irq_clr) begin
      st_next.mask = st_reg.mask & ~wdata_valid;
    end

    // Configuration accepted only while unprotected; reserved bits dropped.
    if (wr_cfg_ok) begin
      st_next.fifo_start_mode     = reg_wdata_i[CFG_FIFO_MODE_BIT];
      st_next.flow_err_reset_ctrl = reg_wdata_i[CFG_FLOW_ERR_BIT];
      st_next.high_speed_edge     = reg_wdata_i[CFG_HIGH_SPD_BIT];
      st_next.last_block_sync     = reg_wdata_i[CFG_LAST_SYNC_BIT];
    end

    // Protection switch reacts only to the right key.
    if (wr_wprot && wprot_key_ok) begin
      st_next.wprot_enable = reg_wdata_i[WP_ENABLE_BIT];
    end

    // Underrun: clears first, then the event, so a byte lost in the very
    // cycle of a clear is still reported.
    if (xfer_cmd_i || rd_flow_clear ||
        (wr_cfg_ok && reg_wdata_i[CFG_FLOW_ERR_BIT])) begin
      st_next.tx_underrun_flag = 1'h0;
    end
    if (tx_underrun_evt_i) begin
      st_next.tx_underrun_flag = 1'h1;
    end

    // Overrun: held until a command, or a status read in flow mode one.
    if (xfer_cmd_i || rd_flow_clear) begin
      st_next.rx_overrun_flag = 1'h0;
    end
    if (rx_overrun_evt_i) begin
      st_next.rx_overrun_flag = 1'h1;
    end

    // Interrupt follows enabled flags with one register stage.
    st_next.irq = |(flags_now & st_reg.mask);

    // Write start threshold.
    if (st_reg.fifo_start_mode) begin
      st_next.start_ok = fifo_level_i >= FIFO_ONE_WORD;
    end else if (block_len_i >= FIFO_THREE_QTR) begin
      st_next.start_ok = fifo_level_i >= FIFO_HALF;
    end else if (block_len_i >= FIFO_HALF) begin
      st_next.start_ok = fifo_level_i >= FIFO_QUARTER;
    end else begin
      st_next.start_ok = fifo_level_i >= xfer_bytes_i;
    end

    // Pending command released at block end or at transfer end; software
    // must only pick transfer end with a finite block count.
    if (st_reg.last_block_sync) begin
      st_next.cmd_issue = cmd_pending_i && xfer_end_i;
    end else begin
      st_next.cmd_issue = cmd_pending_i && block_end_i;
    end

    // Read data stand for one cycle only; write-only and unmapped read zero.
    st_next.rdata = RDATA_RESET;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_STATUS: begin
          st_next.rdata = flags_now;
        end
        ADDR_IRQ_STATE: begin
          st_next.rdata = st_reg.mask;
        end
        ADDR_HOST_CFG: begin
          st_next.rdata[CFG_FIFO_MODE_BIT] = st_reg.fifo_start_mode;
          st_next.rdata[CFG_FLOW_ERR_BIT]  = st_reg.flow_err_reset_ctrl;
          st_next.rdata[CFG_HIGH_SPD_BIT]  = st_reg.high_speed_edge;
          st_next.rdata[CFG_LAST_SYNC_BIT] = st_reg.last_block_sync;
        end
        ADDR_WPROT_MODE: begin
          st_next.rdata[WP_ENABLE_BIT] = st_reg.wprot_enable;
        end
        default: begin
          st_next.rdata = RDATA_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; synchronous reset to constants only.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st_reg.mask                <= MASK_RESET;
      st_reg.fifo_start_mode     <= BIT_RESET;
      st_reg.flow_err_reset_ctrl <= BIT_RESET;
      st_reg.high_speed_edge     <= BIT_RESET;
      st_reg.last_block_sync     <= BIT_RESET;
      st_reg.wprot_enable        <= BIT_RESET;
      st_reg.tx_underrun_flag    <= BIT_RESET;
      st_reg.rx_overrun_flag     <= BIT_RESET;
      st_reg.irq                 <= BIT_RESET;
      st_reg.start_ok            <= BIT_RESET;
      st_reg.cmd_issue           <= BIT_RESET;
      st_reg.rdata               <= RDATA_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata_o       = st_reg.rdata;
  assign irq_o             = st_reg.irq;
  assign wr_start_ok_o     = st_reg.start_ok;
  assign cmd_issue_o       = st_reg.cmd_issue;
  assign high_speed_edge_o = st_reg.high_speed_edge;
  assign wprot_enable_o    = st_reg.wprot_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the slice's own behaviour.
  default clocking cb_sys @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // Enable write leaves every written valid bit set.
  a_mask_set_bits:
    assert property (wr_irq_set |=> ((st_reg.mask & $past(wdata_valid)) == $past(wdata_valid)))
    else $error("enable write did not set mask bits");

  // Disable write leaves every written valid bit clear, others untouched.
  a_mask_clear_bits:
    assert property (wr_irq_clr |=>
      (st_reg.mask == ($past(st_reg.mask) & ~$past(wdata_valid))))
    else $error("disable write did not clear mask bits");

  // Reserved mask positions never become set.
  a_mask_reserved_zero:
    assert property ((st_reg.mask & ~FLAG_VALID_MASK) == 32'h0000_0000)
    else $error("reserved mask bit set");

  // Mask read returns the mask of the read cycle, then zero.
  a_mask_read_back:
    assert property ((reg_rd_i && reg_addr_i == ADDR_IRQ_STATE) |=>
      (reg_rdata_o == $past(st_reg.mask)) ##1 (reg_rdata_o == 32'h0000_0000 || $past(reg_rd_i)))
    else $error("mask read data wrong");

  // Protected configuration keeps its value across a write.
  a_cfg_locked:
    assert property ((wr_cfg && st_reg.wprot_enable) |=>
      ($stable(st_reg.fifo_start_mode) && $stable(st_reg.flow_err_reset_ctrl) &&
       $stable(st_reg.high_speed_edge) && $stable(st_reg.last_block_sync)))
    else $error("configuration changed while protected");

  // Wrong key leaves protection state alone.
  a_wprot_bad_key:
    assert property ((wr_wprot && !wprot_key_ok) |=> $stable(st_reg.wprot_enable))
    else $error("protection changed with wrong key");

  // Correct key copies the enable bit.
  a_wprot_good_key:
    assert property ((wr_wprot && wprot_key_ok) |=>
      (wprot_enable_o == $past(reg_wdata_i[WP_ENABLE_BIT])))
    else $error("protection not updated with right key");

  // Underrun event always shows on the flag next cycle.
  a_underrun_set:
    assert property (tx_underrun_evt_i |=> st_reg.tx_underrun_flag)
    else $error("underrun event lost");

  // Command clears underrun when no new event arrives.
  a_underrun_cmd_clear:
    assert property ((xfer_cmd_i && !tx_underrun_evt_i) |=> !st_reg.tx_underrun_flag)
    else $error("underrun not cleared by command");

  // Status read in flow mode one clears both flow flags.
  a_flow_read_clear:
    assert property ((rd_status && st_reg.flow_err_reset_ctrl &&
                      !tx_underrun_evt_i && !rx_overrun_evt_i) |=>
      (!st_reg.tx_underrun_flag && !st_reg.rx_overrun_flag))
    else $error("flow flags not cleared by status read");

  // Overrun held while no command and no clearing read.
  a_overrun_hold:
    assert property ((st_reg.rx_overrun_flag && !xfer_cmd_i && !rd_flow_clear) |=>
      st_reg.rx_overrun_flag)
    else $error("overrun flag dropped early");

  // Interrupt line equals enabled flags one cycle before.
  a_irq_follows:
    assert property (##1 (irq_o == $past(|(flags_now & st_reg.mask))))
    else $error("interrupt output mismatch");

  // Start mode one allows the write after one word is present.
  a_start_one_word:
    assert property ((st_reg.fifo_start_mode && fifo_level_i >= FIFO_ONE_WORD) |=> wr_start_ok_o)
    else $error("write start missing in mode one");

  // Long block in mode zero waits for half the FIFO.
  a_start_half:
    assert property ((!st_reg.fifo_start_mode && block_len_i >= FIFO_THREE_QTR) |=>
      (wr_start_ok_o == ($past(fifo_level_i) >= FIFO_HALF)))
    else $error("long block start threshold wrong");

  // With block-end sync a pending command is released at the block end.
  a_cmd_release:
    assert property ((cmd_pending_i && !st_reg.last_block_sync) |=>
      (cmd_issue_o == $past(block_end_i)))
    else $error("pending command release wrong");

  // Medium block in mode zero waits for a quarter of the FIFO.
  a_start_quarter:
    assert property ((!st_reg.fifo_start_mode && block_len_i >= FIFO_HALF &&
                      block_len_i < FIFO_THREE_QTR) |=>
      (wr_start_ok_o == ($past(fifo_level_i) >= FIFO_QUARTER)))
    else $error("medium block start threshold wrong");

  // Short block in mode zero waits until the whole transfer is loaded.
  a_start_whole:
    assert property ((!st_reg.fifo_start_mode && block_len_i < FIFO_HALF) |=>
      (wr_start_ok_o == ($past(fifo_level_i) >= $past(xfer_bytes_i))))
    else $error("short block start threshold wrong");

  // Start mode one holds the write back while the FIFO is still empty.
  a_start_mode_empty:
    assert property ((st_reg.fifo_start_mode && fifo_level_i < FIFO_ONE_WORD) |=>
      !wr_start_ok_o)
    else $error("write start too early in mode one");

  // With transfer-end sync a pending command waits for the transfer end.
  a_cmd_xfer_end:
    assert property ((cmd_pending_i && st_reg.last_block_sync) |=>
      (cmd_issue_o == $past(xfer_end_i)))
    else $error("pending command release at transfer end wrong");

  // A command clears overrun when no new loss arrives in that cycle.
  a_overrun_cmd_clear:
    assert property ((xfer_cmd_i && !rx_overrun_evt_i) |=> !st_reg.rx_overrun_flag)
    else $error("overrun not cleared by command");

  // An accepted flow bit write clears underrun unless a new byte is lost.
  a_underrun_cfg_clear:
    assert property ((wr_cfg_ok && reg_wdata_i[CFG_FLOW_ERR_BIT] && !tx_underrun_evt_i) |=>
      !st_reg.tx_underrun_flag)
    else $error("underrun not cleared by flow bit write");

  // Underrun stays set until one of its three clearing events arrives.
  a_underrun_hold:
    assert property ((st_reg.tx_underrun_flag && !xfer_cmd_i && !rd_flow_clear &&
                      !(wr_cfg_ok && reg_wdata_i[CFG_FLOW_ERR_BIT])) |=>
      st_reg.tx_underrun_flag)
    else $error("underrun flag dropped early");

  // The card edge select follows every accepted configuration write.
  a_speed_edge_out:
    assert property (wr_cfg_ok |=>
      (high_speed_edge_o == $past(reg_wdata_i[CFG_HIGH_SPD_BIT])))
    else $error("high speed edge not taken from configuration");

  // Protect mode reads back the enable bit, with the key field as zero.
  a_wprot_read_back:
    assert property ((reg_rd_i && reg_addr_i == ADDR_WPROT_MODE) |=>
      (reg_rdata_o[WP_ENABLE_BIT] == $past(st_reg.wprot_enable) &&
       reg_rdata_o[WP_KEY_MSB:WP_KEY_LSB] == 24'h00_0000))
    else $error("protect mode read data wrong");

  // The mask moves only on an enable or disable write.
  a_mask_hold:
    assert property ((!wr_irq_set && !wr_irq_clr) |=> $stable(st_reg.mask))
    else $error("mask changed without a write");

  // Main scenarios reached.
  c_enable_write: cover property (wr_irq_set ##2 irq_o);
  c_underrun_read_clear: cover property (st_reg.tx_underrun_flag && rd_flow_clear ##1
                                         !st_reg.tx_underrun_flag);
  c_cmd_at_xfer_end: cover property (st_reg.last_block_sync && cmd_pending_i && xfer_end_i);
  c_cfg_blocked: cover property (wr_cfg && st_reg.wprot_enable);
  c_start_long: cover property (!st_reg.fifo_start_mode && block_len_i >= FIFO_THREE_QTR ##1 wr_start_ok_o);

endmodule // chicr_regs

`default_nettype wire

//--- hdl/chicr_pkg.sv
// Package of addresses, field positions, reset values and state type for the card host register slice.
package chicr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the register port.
  localparam logic [31:0] ADDR_STATUS     = 32'h4000_0040;
  localparam logic [31:0] ADDR_IRQ_SET    = 32'h4000_0044;
  localparam logic [31:0] ADDR_IRQ_CLR    = 32'h4000_0048;
  localparam logic [31:0] ADDR_IRQ_STATE  = 32'h4000_004C;
  localparam logic [31:0] ADDR_HOST_CFG   = 32'h4000_0054;
  localparam logic [31:0] ADDR_WPROT_MODE = 32'h4000_00E4;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag layout shared by the status, enable, disable and mask registers.
  localparam int          FLAG_UNDERRUN_BIT = 31;
  localparam int          FLAG_OVERRUN_BIT  = 30;
  localparam int          FLAG_EXT_MSB      = 29;
  localparam logic [31:0] FLAG_VALID_MASK   = 32'hFCFF_F1FF;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration and write-protect field positions.
  localparam int          CFG_FIFO_MODE_BIT = 0;
  localparam int          CFG_FLOW_ERR_BIT  = 4;
  localparam int          CFG_HIGH_SPD_BIT  = 8;
  localparam int          CFG_LAST_SYNC_BIT = 12;
  localparam int          WP_ENABLE_BIT     = 0;
  localparam int          WP_KEY_LSB        = 8;
  localparam int          WP_KEY_MSB        = 31;
  localparam logic [23:0] WP_KEY_VALUE      = 24'h4D_4349;

  ////////////////////////////////////////////////////////////////////////////////
  // Internal FIFO thresholds in bytes; the FIFO holds 256 words of 4 bytes.
  localparam logic [15:0] FIFO_THREE_QTR = 16'h0300;
  localparam logic [15:0] FIFO_HALF      = 16'h0200;
  localparam logic [15:0] FIFO_QUARTER   = 16'h0100;
  localparam logic [15:0] FIFO_ONE_WORD  = 16'h0004;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic        BIT_RESET   = 1'h0;

  // Complete state of the register slice, held in one register.
  typedef struct packed {
    logic [31:0] mask;
    logic        fifo_start_mode;
    logic        flow_err_reset_ctrl;
    logic        high_speed_edge;
    logic        last_block_sync;
    logic        wprot_enable;
    logic        tx_underrun_flag;
    logic        rx_overrun_flag;
    logic        irq;
    logic        start_ok;
    logic        cmd_issue;
    logic [31:0] rdata;
  } chicr_state_t;

endpackage

//--- test/chicr_card_model.sv
// Behavioural model of the card-side engine: flow events, block ends and write FIFO fill.
`timescale 1ns/1ps
`default_nettype none

module chicr_card_model (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // Bench requests: 1 underrun, 2 command, 3 block end, 4 transfer end, 5 overrun.
  input  wire logic [2:0]  req_i,
  input  wire logic        push_i,
  // Events and fill level towards the register slice.
  output logic             tx_underrun_evt_o,
  output logic             rx_overrun_evt_o,
  output logic             xfer_cmd_o,
  output logic             block_end_o,
  output logic             xfer_end_o,
  output logic [15:0]      fifo_level_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Each request is copied to its event pulse one cycle later, and the pulse lasts as long as the request is held.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_underrun_evt_o <= 1'h0;
      rx_overrun_evt_o  <= 1'h0;
      xfer_cmd_o        <= 1'h0;
      block_end_o       <= 1'h0;
      xfer_end_o        <= 1'h0;
      fifo_level_o      <= 16'h0000;
    end else begin
      tx_underrun_evt_o <= (req_i == 3'h1);
      xfer_cmd_o        <= (req_i == 3'h2);
      block_end_o       <= (req_i == 3'h3);
      xfer_end_o        <= (req_i == 3'h4);
      rx_overrun_evt_o  <= (req_i == 3'h5);
      // A new command empties the FIFO and wins over a push; every other push adds one 32-bit word.
      if (req_i == 3'h2) begin
        fifo_level_o <= 16'h0000;
      end else if (push_i) begin
        fifo_level_o <= fifo_level_o + 16'h0004;
      end
    end
  end
endmodule // chicr_card_model

`default_nettype wire

//--- test/chicr_regs_test.sv
// Self-checking testbench of the card host register slice.
`timescale 1ns/1ps
`default_nettype none

module chicr_regs_test;
  import chicr_pkg::*;
  logic clk_sys_i = 1'h0, reset_n_i = 1'h0, wr = 1'h0, rd = 1'h0, push = 1'h0, pend = 1'h0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
  logic [29:0] flags = 30'h0;
  logic [15:0] blk = 16'h0, xf = 16'h0, lvl;
  logic [2:0] req = 3'h0;
  logic und, ovr, cmd, bend, xend, irq, ok, iss, hs, wp;
  int fails = 0, checked = 0, cyc = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  chicr_card_model card_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req),
    .push_i(push), .tx_underrun_evt_o(und), .rx_overrun_evt_o(ovr), .xfer_cmd_o(cmd),
    .block_end_o(bend), .xfer_end_o(xend), .fifo_level_o(lvl));
  chicr_regs dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .status_flags_i(flags), .tx_underrun_evt_i(und), .rx_overrun_evt_i(ovr),
    .xfer_cmd_i(cmd), .block_len_i(blk), .xfer_bytes_i(xf), .fifo_level_i(lvl),
    .cmd_pending_i(pend), .block_end_i(bend), .xfer_end_i(xend), .irq_o(irq),
    .wr_start_ok_o(ok), .cmd_issue_o(iss), .high_speed_edge_o(hs), .wprot_enable_o(wp));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared checking and bus tasks.
  task automatic summarize();
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bwr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i) {wr, addr, wdata} <= {1'h1, a, d};
    @(posedge clk_sys_i) wr <= 1'h0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic brd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i) {rd, addr} <= {1'h1, a};
    @(posedge clk_sys_i) rd <= 1'h0;
    #1 chk("read data", rdata, exp);
  endtask

  task automatic ev(input logic [2:0] k);
    @(posedge clk_sys_i) req <= k;
    @(posedge clk_sys_i) req <= 3'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic mask_regs();
    brd(ADDR_IRQ_STATE, 32'h0);
    brd(ADDR_HOST_CFG, 32'h0);
    brd(ADDR_IRQ_SET, 32'h0);
    brd(32'h4000_0050, 32'h0);
    bwr(ADDR_IRQ_SET, 32'hFFFF_FFFF);
    brd(ADDR_IRQ_STATE, FLAG_VALID_MASK);
    bwr(ADDR_IRQ_CLR, 32'h0000_00FF);
    brd(ADDR_IRQ_STATE, 32'hFCFF_F100);
    bwr(ADDR_IRQ_SET, 32'h0);
    bwr(ADDR_IRQ_STATE, 32'h0);
    brd(ADDR_IRQ_STATE, 32'hFCFF_F100);
    bwr(ADDR_IRQ_CLR, 32'hFFFF_FFFF);
    brd(ADDR_IRQ_STATE, 32'h0);
  endtask

  task automatic irq_path();
    @(posedge clk_sys_i) flags <= 30'h0000_0201;
    bwr(ADDR_IRQ_SET, 32'h0000_0200);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("irq reserved", irq, 32'h0);
    bwr(ADDR_IRQ_SET, 32'h0000_0001);
    @(posedge clk_sys_i);
    #1 chk("irq on", irq, 32'h1);
    bwr(ADDR_IRQ_CLR, 32'h0000_0001);
    @(posedge clk_sys_i);
    #1 chk("irq off", irq, 32'h0);
    @(posedge clk_sys_i) flags <= 30'h0;
    bwr(ADDR_IRQ_SET, 32'h8000_0000);
    ev(3'h1);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("irq underrun", irq, 32'h1);
  endtask

  task automatic flow_flags();
    brd(ADDR_STATUS, 32'h8000_0000);
    brd(ADDR_STATUS, 32'h8000_0000);
    ev(3'h2);
    brd(ADDR_STATUS, 32'h0);
    ev(3'h1);
    bwr(ADDR_HOST_CFG, 32'h0000_0010);
    brd(ADDR_STATUS, 32'h0);
    ev(3'h1);
    brd(ADDR_STATUS, 32'h8000_0000);
    brd(ADDR_STATUS, 32'h0);
    ev(3'h5);
    brd(ADDR_STATUS, 32'h4000_0000);
    brd(ADDR_STATUS, 32'h0);
    bwr(ADDR_HOST_CFG, 32'h0);
    ev(3'h5);
    brd(ADDR_STATUS, 32'h4000_0000);
    ev(3'h2);
    brd(ADDR_STATUS, 32'h0);
  endtask

  task automatic protect();
    bwr(ADDR_HOST_CFG, 32'hFFFF_FFFF);
    chk("high speed", hs, 32'h1);
    brd(ADDR_HOST_CFG, 32'h0000_1111);
    bwr(ADDR_WPROT_MODE, 32'h4D43_4801);
    chk("protect bad key", wp, 32'h0);
    bwr(ADDR_WPROT_MODE, 32'h4D43_4901);
    chk("protect on", wp, 32'h1);
    brd(ADDR_WPROT_MODE, 32'h0000_0001);
    bwr(ADDR_HOST_CFG, 32'h0);
    brd(ADDR_HOST_CFG, 32'h0000_1111);
    bwr(ADDR_WPROT_MODE, 32'h4D43_4900);
    chk("protect off", wp, 32'h0);
    bwr(ADDR_HOST_CFG, 32'h0);
    chk("high speed", hs, 32'h0);
  endtask

  // Fills to one word below the threshold, then one word more.
  task automatic start_case(input logic mode, input logic [15:0] b, input logic [15:0] x,
                            input int words);
    bwr(ADDR_HOST_CFG, {31'h0, mode});
    @(posedge clk_sys_i) {blk, xf} <= {b, x};
    ev(3'h2);
    for (int i = 0; i < words; i++) begin
      @(posedge clk_sys_i) push <= 1'h1;
      @(posedge clk_sys_i) push <= 1'h0;
    end
    repeat (2) @(posedge clk_sys_i);
    #1 chk("start early", ok, 32'h0);
    @(posedge clk_sys_i) push <= 1'h1;
    @(posedge clk_sys_i) push <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("start due", ok, 32'h1);
  endtask

  task automatic cmd_case(input logic sync, input logic [2:0] k, input logic exp);
    bwr(ADDR_HOST_CFG, {19'h0, sync, 12'h0});
    @(posedge clk_sys_i) pend <= 1'h1;
    ev(k);
    @(posedge clk_sys_i);
    #1 chk("command issue", iss, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    mask_regs();
    irq_path();
    flow_flags();
    protect();
    start_case(1'h0, 16'd768, 16'd0, 127);
    start_case(1'h0, 16'd767, 16'd0, 63);
    start_case(1'h0, 16'd512, 16'd0, 63);
    start_case(1'h0, 16'd511, 16'd300, 74);
    start_case(1'h1, 16'd100, 16'd0, 0);
    cmd_case(1'h0, 3'h3, 1'h1);
    cmd_case(1'h0, 3'h4, 1'h0);
    cmd_case(1'h1, 3'h3, 1'h0);
    cmd_case(1'h1, 3'h4, 1'h1);
    summarize();
  end
endmodule // chicr_regs_test

`default_nettype wire
